/* rtl/fsp_pkg.sv */
// Purpose: Shared constants of the flash self-program controller
// Assumes: 14-bit words and addresses, 8-bit register port
// Notes:   Register selects and control bit layout used by both ends
package fsp_pkg;
  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W   = 14;
  localparam int unsigned WORD_W   = 14;
  localparam int unsigned LATCHES  = 8;
  localparam int unsigned LATCH_IW = 3;
  localparam int unsigned ROW_IW   = 5;
  localparam logic [13:0] LATCH_RESET = 14'h3fff;

  // ---------------------------------------------------------------
  // Register selects
  // ---------------------------------------------------------------
  localparam logic [2:0] SEL_ADDR_LO = 3'h0;
  localparam logic [2:0] SEL_ADDR_HI = 3'h1;
  localparam logic [2:0] SEL_WORD_LO = 3'h2;
  localparam logic [2:0] SEL_WORD_HI = 3'h3;
  localparam logic [2:0] SEL_CTRL    = 3'h4;
  localparam logic [2:0] SEL_UNLOCK  = 3'h5;

  // ---------------------------------------------------------------
  // Control register bits
  // ---------------------------------------------------------------
  localparam int unsigned B_RD     = 0;
  localparam int unsigned B_WR     = 1;
  localparam int unsigned B_PERMIT = 2;
  localparam int unsigned B_ERASE  = 3;
  localparam int unsigned B_LATCH  = 4;
  localparam int unsigned B_CFG    = 6;
  localparam int unsigned B_PROG   = 7;
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned BUSY_TIME_NS  = 2000000;
  localparam int unsigned BUSY_CYCLES   = BUSY_TIME_NS / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Core side operations and step kinds
  // ---------------------------------------------------------------
  localparam logic [1:0] OP_READ  = 2'h0;
  localparam logic [1:0] OP_ERASE = 2'h1;
  localparam logic [1:0] OP_LOAD  = 2'h2;
  localparam logic [1:0] OP_PROG  = 2'h3;
  localparam logic [1:0] K_NOP = 2'h0;
  localparam logic [1:0] K_WR  = 2'h1;
  localparam logic [1:0] K_RD  = 2'h2;
  localparam logic [1:0] K_END = 2'h3;
endpackage

/* rtl/fsp_if.sv */
// Purpose: Register port between core and flash controller
// Assumes: Single clock, all signals synchronous
// Notes:   Accesses are taken only while stall is low
`timescale 1ns/1ps
interface fsp_if;
  logic       reg_we;
  logic       reg_re;
  logic [2:0] reg_sel;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       stall;

  modport core (
    output reg_we,
    output reg_re,
    output reg_sel,
    output reg_wdata,
    input  reg_rdata,
    input  stall
  );

  modport ctrl (
    input  reg_we,
    input  reg_re,
    input  reg_sel,
    input  reg_wdata,
    output reg_rdata,
    output stall
  );
endinterface

/* rtl/fsp_ctrl_end.sv */
// Purpose: Flash self-program controller, device end
// Assumes: Flash array answers a read within the read pulse cycle
// Notes:   Register accesses are ignored while the core is stalled
//
// Summary of operation
// - Read strobe fetches word at loaded address
// - Read uses second cycle after strobe
// - Fetched word held until reread or write
// - Core puts two no-ops after read
// - Reads ignore code protection setting
// - Erase whole aligned 32-word row
// - Eight aligned latches, never crossed
// - Erase needs setup bits, key, strobe
// - Erase select clears when erase done
// - Two setup cycles after write strobe
// - Erase stalls core 2 ms, clocks run
// - Core resumes third instruction after strobe
// - Programming never erases first
// - Latch-only strobe loads latch, no stall
// - Normal strobe loads latch, programs block
// - Stall only on final program operation
// - Whole latch block always programmed
// - Latches reset to 3fff after program
// - Every load needs 55h, aah, strobe
// - Write strobe needs permit already set
// - 14-bit latches loaded from data pair
// - Refuse erase or program when protected
`timescale 1ns/1ps
module fsp_ctrl_end #(
  parameter int unsigned BUSY_CYCLES = fsp_pkg::BUSY_CYCLES
) (
  // Clock and reset
  input  wire logic         i_mclk,
  input  wire logic         i_reset_n,
  // Core register port
  fsp_if.ctrl               bus,
  // Flash array
  output logic [13:0]       o_flash_addr,
  output logic              o_flash_rd,
  input  wire logic [13:0]  i_flash_rdata,
  output logic              o_flash_erase,
  output logic              o_flash_prog,
  output logic [111:0]      o_flash_block,
  // Protection and status
  input  wire logic [13:0]  i_protect_limit,
  output logic              o_refused,
  output logic              o_busy
);
  localparam int unsigned TW = $clog2(BUSY_CYCLES + 1);
  localparam logic [TW-1:0] T_LOAD = TW'(BUSY_CYCLES - 1);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RD1  = 3'b001,
    ST_RD2  = 3'b010,
    ST_SET1 = 3'b011,
    ST_SET2 = 3'b100,
    ST_BUSY = 3'b101
  } fsp_state_t;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  fsp_state_t    state_ff;
  logic [7:0]    addr_lo_ff;
  logic [5:0]    addr_hi_ff;
  logic [7:0]    word_lo_ff;
  logic [5:0]    word_hi_ff;
  logic          rd_ff;
  logic          wr_ff;
  logic          permit_ff;
  logic          erase_ff;
  logic          latch_only_ff;
  logic          cfg_ff;
  logic          prog_ff;
  logic [1:0]    key_ff;
  logic [13:0]   latch_ff [fsp_pkg::LATCHES];
  logic [TW-1:0] timer_ff;
  logic          stall_ff;
  logic [7:0]    rdata_ff;
  logic [13:0]   faddr_ff;
  logic          frd_ff;
  logic          ferase_ff;
  logic          fprog_ff;
  logic          refused_ff;
  logic          busy_ff;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  logic        take;
  logic        wr_ctrl;
  logic [7:0]  wd;
  logic [13:0] addr;
  logic        rd_go;
  logic        wr_go;
  logic        w_latch;
  logic        w_erase;
  logic        blocked;
  logic        op_go;
  logic        done;

  assign take    = !stall_ff;
  assign wd      = bus.reg_wdata;
  assign wr_ctrl = take && bus.reg_we && bus.reg_sel == fsp_pkg::SEL_CTRL;
  assign addr    = {addr_hi_ff, addr_lo_ff};
  // Program space on, config space off
  assign rd_go   = wr_ctrl && wd[fsp_pkg::B_RD] && wd[fsp_pkg::B_PROG] &&
                   !wd[fsp_pkg::B_CFG] && state_ff == ST_IDLE;
  // Permit must already be set, key pair complete
  assign wr_go   = wr_ctrl && wd[fsp_pkg::B_WR] && permit_ff &&
                   key_ff == 2'h2 && wd[fsp_pkg::B_PROG] &&
                   !wd[fsp_pkg::B_CFG] && state_ff == ST_IDLE;
  assign w_erase = wd[fsp_pkg::B_ERASE];
  assign w_latch = wd[fsp_pkg::B_LATCH] && !w_erase;
  assign blocked = addr < i_protect_limit;
  assign op_go   = wr_go && !w_latch && !blocked;
  assign done    = state_ff == ST_BUSY && timer_ff == '0;

  // ---------------------------------------------------------------
  // Unlock key tracker
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      key_ff <= 2'h0;
    end else if (take && bus.reg_we) begin
      if (bus.reg_sel != fsp_pkg::SEL_UNLOCK) begin
        key_ff <= 2'h0;
      end else if (wd == fsp_pkg::KEY_FIRST) begin
        key_ff <= 2'h1;
      end else if (wd == fsp_pkg::KEY_SECOND && key_ff == 2'h1) begin
        key_ff <= 2'h2;
      end else begin
        key_ff <= 2'h0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Address and data registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      addr_lo_ff <= 8'h00;
      addr_hi_ff <= 6'h00;
    end else if (take && bus.reg_we) begin
      if (bus.reg_sel == fsp_pkg::SEL_ADDR_LO) begin
        addr_lo_ff <= wd;
      end
      if (bus.reg_sel == fsp_pkg::SEL_ADDR_HI) begin
        addr_hi_ff <= wd[5:0];
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      word_lo_ff <= 8'h00;
      word_hi_ff <= 6'h00;
    end else if (state_ff == ST_RD2) begin
      word_lo_ff <= i_flash_rdata[7:0];
      word_hi_ff <= i_flash_rdata[13:8];
    end else if (take && bus.reg_we) begin
      if (bus.reg_sel == fsp_pkg::SEL_WORD_LO) begin
        word_lo_ff <= wd;
      end
      if (bus.reg_sel == fsp_pkg::SEL_WORD_HI) begin
        word_hi_ff <= wd[5:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      permit_ff     <= 1'b0;
      latch_only_ff <= 1'b0;
      cfg_ff        <= 1'b0;
      prog_ff       <= 1'b0;
    end else if (wr_ctrl) begin
      permit_ff     <= wd[fsp_pkg::B_PERMIT];
      latch_only_ff <= wd[fsp_pkg::B_LATCH];
      cfg_ff        <= wd[fsp_pkg::B_CFG];
      prog_ff       <= wd[fsp_pkg::B_PROG];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      erase_ff <= 1'b0;
    end else if (wr_ctrl) begin
      erase_ff <= wd[fsp_pkg::B_ERASE];
    end else if (done) begin
      erase_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      rd_ff <= 1'b0;
      wr_ff <= 1'b0;
    end else begin
      if (rd_go) begin
        rd_ff <= 1'b1;
      end else if (state_ff == ST_RD2) begin
        rd_ff <= 1'b0;
      end
      if (op_go) begin
        wr_ff <= 1'b1;
      end else if (done) begin
        wr_ff <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Sequencer and stall timer
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      state_ff <= ST_IDLE;
      timer_ff <= '0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (rd_go) begin
            state_ff <= ST_RD1;
          end else if (op_go) begin
            state_ff <= ST_SET1;
          end
        end
        ST_RD1: state_ff <= ST_RD2;
        ST_RD2: state_ff <= ST_IDLE;
        ST_SET1: state_ff <= ST_SET2;
        ST_SET2: begin
          state_ff <= ST_BUSY;
          timer_ff <= T_LOAD;
        end
        ST_BUSY: begin
          if (timer_ff == '0) begin
            state_ff <= ST_IDLE;
          end else begin
            timer_ff <= timer_ff - 1'b1;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Stall in the read slot and through the whole busy time
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      stall_ff <= 1'b0;
    end else begin
      stall_ff <= state_ff == ST_RD1 || state_ff == ST_SET2 ||
                  (state_ff == ST_BUSY && timer_ff != '0);
    end
  end

  // ---------------------------------------------------------------
  // Write latches
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      for (int i = 0; i < fsp_pkg::LATCHES; i++) begin
        latch_ff[i] <= fsp_pkg::LATCH_RESET;
      end
    end else if (done && !erase_ff) begin
      for (int i = 0; i < fsp_pkg::LATCHES; i++) begin
        latch_ff[i] <= fsp_pkg::LATCH_RESET;
      end
    end else if (wr_go && !w_erase) begin
      latch_ff[addr_lo_ff[2:0]] <= {word_hi_ff, word_lo_ff};
    end
  end

  always_comb begin
    o_flash_block = '0;
    for (int i = 0; i < fsp_pkg::LATCHES; i++) begin
      o_flash_block[i*14 +: 14] = latch_ff[i];
    end
  end

  // ---------------------------------------------------------------
  // Flash array commands
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      faddr_ff  <= 14'h0000;
      frd_ff    <= 1'b0;
      ferase_ff <= 1'b0;
      fprog_ff  <= 1'b0;
    end else begin
      frd_ff    <= state_ff == ST_RD1;
      ferase_ff <= state_ff == ST_SET2 && erase_ff;
      fprog_ff  <= state_ff == ST_SET2 && !erase_ff;
      if (state_ff == ST_RD1) begin
        faddr_ff <= addr;
      end else if (state_ff == ST_SET2 && erase_ff) begin
        faddr_ff <= {addr[13:fsp_pkg::ROW_IW], 5'h00};
      end else if (state_ff == ST_SET2) begin
        faddr_ff <= {addr[13:fsp_pkg::LATCH_IW], 3'h0};
      end
    end
  end

  // ---------------------------------------------------------------
  // Read port and status
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      rdata_ff <= 8'h00;
    end else if (take && bus.reg_re) begin
      case (bus.reg_sel)
        fsp_pkg::SEL_ADDR_LO: rdata_ff <= addr_lo_ff;
        fsp_pkg::SEL_ADDR_HI: rdata_ff <= {2'b00, addr_hi_ff};
        fsp_pkg::SEL_WORD_LO: rdata_ff <= word_lo_ff;
        fsp_pkg::SEL_WORD_HI: rdata_ff <= {2'b00, word_hi_ff};
        fsp_pkg::SEL_CTRL: begin
          rdata_ff <= {prog_ff, cfg_ff, 1'b0, latch_only_ff,
                       erase_ff, permit_ff, wr_ff, rd_ff};
        end
        default: rdata_ff <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      refused_ff <= 1'b0;
      busy_ff    <= 1'b0;
    end else begin
      refused_ff <= wr_go && !w_latch && blocked;
      busy_ff    <= state_ff != ST_IDLE || rd_go || op_go;
    end
  end

  assign bus.reg_rdata = rdata_ff;
  assign bus.stall     = stall_ff;
  assign o_flash_addr  = faddr_ff;
  assign o_flash_rd    = frd_ff;
  assign o_flash_erase = ferase_ff;
  assign o_flash_prog  = fprog_ff;
  assign o_refused     = refused_ff;
  assign o_busy        = busy_ff;
endmodule

/* rtl/fsp_core_end.sv */
// Purpose: Core side sequencer issuing self-program register steps
// Assumes: One register access per cycle, holds while stalled
// Notes:   A held access is taken when the stall ends
`timescale 1ns/1ps
module fsp_core_end (
  // Clock and reset
  input  wire logic         i_mclk,
  input  wire logic         i_reset_n,
  // Controller register port
  fsp_if.core               bus,
  // Operation request
  input  wire logic         i_op_valid,
  input  wire logic [1:0]   i_op_code,
  input  wire logic [13:0]  i_op_addr,
  input  wire logic [13:0]  i_op_data,
  output logic              o_op_ready,
  // Completion
  output logic              o_done,
  output logic [13:0]       o_rdata
);
  // ---------------------------------------------------------------
  // Step table
  // ---------------------------------------------------------------
  function automatic logic [12:0] step_act(
    input logic [1:0]  op,
    input logic [3:0]  idx,
    input logic [13:0] a,
    input logic [13:0] d
  );
    logic [7:0] c;
    logic [7:0] s;
    logic [12:0] r;
    c = 8'h00;
    c[fsp_pkg::B_PROG]   = 1'b1;
    c[fsp_pkg::B_PERMIT] = op != fsp_pkg::OP_READ;
    c[fsp_pkg::B_ERASE]  = op == fsp_pkg::OP_ERASE;
    c[fsp_pkg::B_LATCH]  = op == fsp_pkg::OP_LOAD;
    s = c;
    s[fsp_pkg::B_WR] = 1'b1;
    r = {fsp_pkg::K_END, 3'h0, 8'h00};
    case (idx)
      4'h0: r = {fsp_pkg::K_WR, fsp_pkg::SEL_ADDR_LO, a[7:0]};
      4'h1: r = {fsp_pkg::K_WR, fsp_pkg::SEL_ADDR_HI, 2'b00, a[13:8]};
      default: r = {fsp_pkg::K_END, 3'h0, 8'h00};
    endcase
    if (op == fsp_pkg::OP_READ) begin
      case (idx)
        4'h0, 4'h1: r = r;
        4'h2: begin
          c[fsp_pkg::B_RD] = 1'b1;
          r = {fsp_pkg::K_WR, fsp_pkg::SEL_CTRL, c};
        end
        4'h3, 4'h4, 4'h7: r = {fsp_pkg::K_NOP, 11'h000};
        4'h5: r = {fsp_pkg::K_RD, fsp_pkg::SEL_WORD_LO, 8'h00};
        4'h6: r = {fsp_pkg::K_RD, fsp_pkg::SEL_WORD_HI, 8'h00};
        default: r = {fsp_pkg::K_END, 11'h000};
      endcase
    end else if (op == fsp_pkg::OP_ERASE) begin
      case (idx)
        4'h0, 4'h1: r = r;
        4'h2: r = {fsp_pkg::K_WR, fsp_pkg::SEL_CTRL, c};
        4'h3: r = {fsp_pkg::K_WR, fsp_pkg::SEL_UNLOCK, fsp_pkg::KEY_FIRST};
        4'h4: r = {fsp_pkg::K_WR, fsp_pkg::SEL_UNLOCK, fsp_pkg::KEY_SECOND};
        4'h5: r = {fsp_pkg::K_WR, fsp_pkg::SEL_CTRL, s};
        4'h6, 4'h7: r = {fsp_pkg::K_NOP, 11'h000};
        4'h8: r = {fsp_pkg::K_WR, fsp_pkg::SEL_CTRL, 8'h00};
        default: r = {fsp_pkg::K_END, 11'h000};
      endcase
    end else begin
      case (idx)
        4'h0, 4'h1: r = r;
        4'h2: r = {fsp_pkg::K_WR, fsp_pkg::SEL_WORD_LO, d[7:0]};
        4'h3: r = {fsp_pkg::K_WR, fsp_pkg::SEL_WORD_HI, 2'b00, d[13:8]};
        4'h4: r = {fsp_pkg::K_WR, fsp_pkg::SEL_CTRL, c};
        4'h5: r = {fsp_pkg::K_WR, fsp_pkg::SEL_UNLOCK, fsp_pkg::KEY_FIRST};
        4'h6: r = {fsp_pkg::K_WR, fsp_pkg::SEL_UNLOCK, fsp_pkg::KEY_SECOND};
        4'h7: r = {fsp_pkg::K_WR, fsp_pkg::SEL_CTRL, s};
        4'h8, 4'h9: r = {fsp_pkg::K_NOP, 11'h000};
        4'ha: begin
          if (op == fsp_pkg::OP_PROG) begin
            r = {fsp_pkg::K_WR, fsp_pkg::SEL_CTRL, 8'h00};
          end else begin
            r = {fsp_pkg::K_END, 11'h000};
          end
        end
        default: r = {fsp_pkg::K_END, 11'h000};
      endcase
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic        run_ff;
  logic [1:0]  op_ff;
  logic [13:0] addr_ff;
  logic [13:0] data_ff;
  logic [3:0]  idx_ff;
  logic        we_ff;
  logic        re_ff;
  logic [2:0]  sel_ff;
  logic [7:0]  wdata_ff;
  logic        re_q_ff;
  logic [2:0]  sel_q_ff;
  logic [13:0] rdata_ff;
  logic        done_ff;
  logic        ready_ff;
  logic [12:0] act;

  assign act = step_act(op_ff, idx_ff, addr_ff, data_ff);

  // ---------------------------------------------------------------
  // Step engine, frozen while stalled
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      run_ff   <= 1'b0;
      op_ff    <= fsp_pkg::OP_READ;
      addr_ff  <= 14'h0000;
      data_ff  <= 14'h0000;
      idx_ff   <= 4'h0;
      we_ff    <= 1'b0;
      re_ff    <= 1'b0;
      sel_ff   <= 3'h0;
      wdata_ff <= 8'h00;
      done_ff  <= 1'b0;
      ready_ff <= 1'b0;
    end else if (!bus.stall) begin
      done_ff <= 1'b0;
      if (!run_ff) begin
        we_ff    <= 1'b0;
        re_ff    <= 1'b0;
        ready_ff <= !(i_op_valid && ready_ff);
        if (i_op_valid && ready_ff) begin
          run_ff  <= 1'b1;
          op_ff   <= i_op_code;
          addr_ff <= i_op_addr;
          data_ff <= i_op_data;
          idx_ff  <= 4'h0;
        end
      end else begin
        we_ff    <= act[12:11] == fsp_pkg::K_WR;
        re_ff    <= act[12:11] == fsp_pkg::K_RD;
        sel_ff   <= act[10:8];
        wdata_ff <= act[7:0];
        idx_ff   <= idx_ff + 4'h1;
        if (act[12:11] == fsp_pkg::K_END) begin
          run_ff   <= 1'b0;
          done_ff  <= 1'b1;
          ready_ff <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Read data capture
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      re_q_ff  <= 1'b0;
      sel_q_ff <= 3'h0;
      rdata_ff <= 14'h0000;
    end else begin
      re_q_ff  <= re_ff && !bus.stall;
      sel_q_ff <= sel_ff;
      if (re_q_ff && sel_q_ff == fsp_pkg::SEL_WORD_LO) begin
        rdata_ff[7:0] <= bus.reg_rdata;
      end
      if (re_q_ff && sel_q_ff == fsp_pkg::SEL_WORD_HI) begin
        rdata_ff[13:8] <= bus.reg_rdata[5:0];
      end
    end
  end

  assign bus.reg_we    = we_ff;
  assign bus.reg_re    = re_ff;
  assign bus.reg_sel   = sel_ff;
  assign bus.reg_wdata = wdata_ff;
  assign o_op_ready    = ready_ff;
  assign o_done        = done_ff;
  assign o_rdata       = rdata_ff;
endmodule

/* bench/fsp_assertions.sv */
// Purpose: Timing checks on the core to controller link
// Assumes: Small busy count, protection limit zero
// Notes:   Watches the first interface only
`timescale 1ns/1ps
module fsp_assertions #(
  parameter int unsigned BUSY_CYCLES = 8
) (
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_reset_n,
  // Link signals
  input  wire logic       reg_we,
  input  wire logic       reg_re,
  input  wire logic [2:0] reg_sel,
  input  wire logic [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       stall
);
  logic        k1_ff;
  logic        k2_ff;
  logic        pm_ff;
  logic [19:0] run_ff;
  wire         tw = reg_we && !stall;
  wire         cw = tw && reg_sel == fsp_pkg::SEL_CTRL;
  wire         uw = tw && reg_sel == fsp_pkg::SEL_UNLOCK;
  wire         ww = cw && reg_wdata[fsp_pkg::B_WR];
  wire         go = ww && k2_ff && pm_ff;
  wire         lo = reg_wdata[fsp_pkg::B_LATCH] && !reg_wdata[fsp_pkg::B_ERASE];

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      k1_ff <= 1'b0;
      k2_ff <= 1'b0;
      pm_ff <= 1'b0;
    end else if (tw) begin
      k1_ff <= uw && reg_wdata == fsp_pkg::KEY_FIRST;
      k2_ff <= uw && k1_ff && reg_wdata == fsp_pkg::KEY_SECOND;
      if (cw) pm_ff <= reg_wdata[fsp_pkg::B_PERMIT];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) run_ff <= 20'h0;
    else if (stall) run_ff <= run_ff + 20'h1;
    else run_ff <= 20'h0;
  end

  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  sequence s_setup; ##1 !stall ##1 !stall; endsequence
  sequence s_read; ##1 !stall ##1 stall ##1 !stall; endsequence

  a_read_slot: assert property (
    cw && reg_wdata[fsp_pkg::B_RD] |-> s_read) else $error("read slot");
  a_op_start: assert property (go && !lo |-> s_setup ##1 stall)
    else $error("erase or program start");
  a_latch_quiet: assert property (go && lo |-> s_setup ##1 !stall[*4])
    else $error("latch load stalled");
  a_key_pair: assert property (ww |-> k2_ff)
    else $error("strobe without key");
  a_permit_first: assert property (ww |-> pm_ff)
    else $error("strobe without permit");
  a_stall_len: assert property ($fell(stall) |-> run_ff == 20'h1 ||
    run_ff == 20'(BUSY_CYCLES)) else $error("stall length");
  a_rdata_hold: assert property (!$past(reg_re && !stall) |->
    $stable(reg_rdata)) else $error("read data moved");
  a_held_access: assert property (stall && reg_we |=> reg_we &&
    $stable(reg_wdata) && $stable(reg_sel)) else $error("access dropped");
endmodule

/* bench/test_flash_self_program_controller.sv */
// Purpose: Bench for both ends of the self-program link
// Assumes: Flash array modelled here, busy count 8
// Notes:   Second controller is driven directly by the bench
`timescale 1ns/1ps
module test_flash_self_program_controller;
  logic          mclk = 1'b0;
  logic          rst_n = 1'b0;
  logic          op_valid = 1'b0;
  logic [1:0]    op_code = 2'h0;
  logic [13:0]   op_addr = 14'h0;
  logic [13:0]   op_data = 14'h0;
  logic          op_ready;
  logic          done;
  logic [13:0]   rdata;
  logic [13:0]   f_addr;
  logic          f_er;
  logic          f_pg;
  logic [111:0]  f_blk;
  logic          ref2;
  logic [13:0]   rd_q;
  logic [13:0]   plim = 14'h0000;
  logic [13:0]   mem [0:16383];
  int            n_mismatch = 0;
  int            n_tests = 0;
  int            n_er = 0;
  int            n_ref = 0;
  int            cyc = 0;
  fsp_if b1();
  fsp_if b2();
  wire  [13:0]   f_rd = mem[f_addr];

  always #2 mclk = ~mclk;

  fsp_core_end i_fsp_core_end (.i_mclk(mclk), .i_reset_n(rst_n), .bus(b1),
    .i_op_valid(op_valid), .i_op_code(op_code), .i_op_addr(op_addr),
    .i_op_data(op_data), .o_op_ready(op_ready), .o_done(done), .o_rdata(rdata));
  fsp_ctrl_end #(.BUSY_CYCLES(8)) i_fsp_ctrl_end (.i_mclk(mclk),
    .i_reset_n(rst_n), .bus(b1), .o_flash_addr(f_addr), .o_flash_rd(),
    .i_flash_rdata(f_rd), .o_flash_erase(f_er), .o_flash_prog(f_pg),
    .o_flash_block(f_blk), .i_protect_limit(plim), .o_refused(),
    .o_busy());
  fsp_ctrl_end #(.BUSY_CYCLES(8)) i_fsp_ctrl_end2 (.i_mclk(mclk),
    .i_reset_n(rst_n), .bus(b2), .o_flash_addr(), .o_flash_rd(),
    .i_flash_rdata(f_rd), .o_flash_erase(), .o_flash_prog(),
    .o_flash_block(), .i_protect_limit(14'h0200), .o_refused(ref2),
    .o_busy());
  fsp_assertions #(.BUSY_CYCLES(8)) i_fsp_assertions (.i_mclk(mclk),
    .i_reset_n(rst_n), .reg_we(b1.reg_we), .reg_re(b1.reg_re),
    .reg_sel(b1.reg_sel), .reg_wdata(b1.reg_wdata),
    .reg_rdata(b1.reg_rdata), .stall(b1.stall));

  always @(posedge mclk) begin
    if (f_er === 1'b1) n_er++;
    if (f_er === 1'b1) for (int i = 0; i < 32; i++)
      mem[{f_addr[13:5], 5'(i)}] = 14'h3fff;
    if (f_pg === 1'b1) for (int i = 0; i < 8; i++)
      mem[{f_addr[13:3], 3'(i)}] &= f_blk[14*i +: 14];
    if (ref2 === 1'b1) n_ref++;
    cyc++;
    if (cyc == 5000) n_mismatch++;
    if (cyc == 5000) end_sim();
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk_w(input string nm, input logic [13:0] e, g);
    n_tests++;
    if (g !== e) n_mismatch++;
    if (g !== e) $display("[FAIL] %s exp %h got %h", nm, e, g);
  endtask

  task automatic do_op(input logic [1:0] c, input logic [13:0] a, d);
    @(posedge mclk);
    op_valid <= 1'b1;
    op_code <= c;
    op_addr <= a;
    op_data <= d;
    @(negedge mclk);
    while (!(op_ready === 1'b1 && b1.stall === 1'b0)) @(negedge mclk);
    @(posedge mclk);
    op_valid <= 1'b0;
    @(negedge mclk);
    while (done !== 1'b1) @(negedge mclk);
    rd_q = rdata;
  endtask

  task automatic rd_chk(input logic [13:0] a, e);
    do_op(fsp_pkg::OP_READ, a, 14'h0);
    chk_w("read word", e, rd_q);
  endtask

  task automatic wr2(input logic [2:0] s, input logic [7:0] w);
    @(posedge mclk);
    b2.reg_we <= 1'b1;
    b2.reg_sel <= s;
    b2.reg_wdata <= w;
    @(posedge mclk);
    b2.reg_we <= 1'b0;
    repeat (2) @(negedge mclk);
  endtask

  task automatic rd2(input logic [2:0] s);
    @(posedge mclk);
    b2.reg_re <= 1'b1;
    b2.reg_sel <= s;
    @(posedge mclk);
    b2.reg_re <= 1'b0;
    @(negedge mclk);
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    b2.reg_we = 1'b0;
    b2.reg_re = 1'b0;
    b2.reg_sel = 3'h0;
    b2.reg_wdata = 8'h00;
    for (int i = 0; i < 16384; i++) mem[i] = (i >= 64 && i <= 96) ? 0 : '1;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    do_op(fsp_pkg::OP_ERASE, 14'h0045, 14'h0);
    rd_chk(14'h0040, 14'h3fff);
    rd_chk(14'h005f, 14'h3fff);
    rd_chk(14'h0060, 14'h0000);
    $display("test erase done");
    do_op(fsp_pkg::OP_LOAD, 14'h0101, 14'h1234);
    chk_w("latch one", 14'h1234, f_blk[27:14]);
    do_op(fsp_pkg::OP_PROG, 14'h0107, 14'h0abc);
    chk_w("latch reset", 14'h3fff, f_blk[27:14]);
    rd_chk(14'h0100, 14'h3fff);
    rd_chk(14'h0101, 14'h1234);
    rd_chk(14'h0107, 14'h0abc);
    do_op(fsp_pkg::OP_PROG, 14'h0060, 14'h3fff);
    rd_chk(14'h0060, 14'h0000);
    chk_w("erase count", 14'h1, 14'(n_er));
    $display("test block write done");
    wr2(fsp_pkg::SEL_UNLOCK, fsp_pkg::KEY_FIRST);
    wr2(fsp_pkg::SEL_UNLOCK, fsp_pkg::KEY_SECOND);
    wr2(fsp_pkg::SEL_CTRL, 8'h8e);
    chk_w("no permit", 14'h0, 14'(n_ref));
    wr2(fsp_pkg::SEL_CTRL, 8'h8e);
    chk_w("no key", 14'h0, 14'(n_ref));
    wr2(fsp_pkg::SEL_UNLOCK, fsp_pkg::KEY_FIRST);
    wr2(fsp_pkg::SEL_UNLOCK, fsp_pkg::KEY_SECOND);
    wr2(fsp_pkg::SEL_CTRL, 8'h8e);
    repeat (4) @(posedge mclk);
    chk_w("refused", 14'h1, 14'(n_ref));
    wr2(fsp_pkg::SEL_ADDR_HI, 8'h02);
    wr2(fsp_pkg::SEL_UNLOCK, fsp_pkg::KEY_FIRST);
    wr2(fsp_pkg::SEL_UNLOCK, fsp_pkg::KEY_SECOND);
    wr2(fsp_pkg::SEL_CTRL, 8'h8e);
    repeat (12) @(posedge mclk);
    rd2(fsp_pkg::SEL_CTRL);
    chk_w("erase bit", 14'h84, {6'h0, b2.reg_rdata});
    $display("test refusal done");
    end_sim();
  end
endmodule
